// *** common/pcd_pkg.sv ***
// shared constants for the pin change edge detector
package pcd_pkg;

  // geometry: three ports of eight pins
  localparam int PORTS = 3;
  localparam int PINS  = 8;

  // apb byte addresses, one aligned word per register
  localparam logic [7:0] ADDR_PORTA_RISE  = 8'h00;
  localparam logic [7:0] ADDR_PORTA_FALL  = 8'h04;
  localparam logic [7:0] ADDR_PORTA_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PORTB_RISE  = 8'h0C;
  localparam logic [7:0] ADDR_PORTB_FALL  = 8'h10;
  localparam logic [7:0] ADDR_PORTB_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_PORTC_RISE  = 8'h18;
  localparam logic [7:0] ADDR_PORTC_FALL  = 8'h1C;
  localparam logic [7:0] ADDR_PORTC_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_CONTROL     = 8'h24;
  localparam logic [7:0] ADDR_AGGREGATE   = 8'h28;
  localparam logic [7:0] ADDR_EVT_STATUS  = 8'h2C;
  localparam logic [7:0] ADDR_EVT_MASK    = 8'h30;

  // per-port address tables, index 0 is port a
  localparam logic [2:0][7:0] ADDR_RISE  = {ADDR_PORTC_RISE, ADDR_PORTB_RISE, ADDR_PORTA_RISE};
  localparam logic [2:0][7:0] ADDR_FALL  = {ADDR_PORTC_FALL, ADDR_PORTB_FALL, ADDR_PORTA_FALL};
  localparam logic [2:0][7:0] ADDR_FLAGS = {ADDR_PORTC_FLAGS, ADDR_PORTB_FLAGS,
                                            ADDR_PORTA_FLAGS};

  // field positions
  localparam int CTRL_MASTER_BIT = 0;  // change_master_irq_enable
  localparam int AGG_FLAG_BIT    = 0;  // change_aggregate_flag

  // reset values
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic       MASTER_RST = 1'b0;
  localparam logic [2:0] EVT_RST    = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;

  // timing: synchroniser depth in pclk cycles
  localparam int SYNC_STAGES = 2;

endpackage

// *** core/pcd_top.sv ***
// Behaviour
// - master enable lets change interrupt wake core
// - sleep edges land in flags before wake
// - port a rise enable arms rising detection
// - port a fall enable arms falling detection
// - port a flag set on enabled edge
// - flag reads zero, software write zero clears
// - port b rise enable arms rising detection
// - port b fall enable arms falling detection
// - port b flag set on enabled edge
// - port c rise enable arms rising detection
// - port c fall enable arms falling detection
// - enable registers read/write, reset to zero
// - flag registers read/write/hardware set, reset zero
// - master off still flags, no interrupt
// - aggregate flag is or of all flags
// - edge during flag write leaves flag set
// - port c flag set on enabled edge
`timescale 1ns/10ps
module pcd_top (
  input  wire logic        pclk,       // system clock, 10 MHz
  input  wire logic        presetn,    // asynchronous reset, active low
  input  wire logic        psel,       // apb select
  input  wire logic        penable,    // apb access phase
  input  wire logic        pwrite,     // apb direction, high for write
  input  wire logic [7:0]  paddr,      // apb byte address
  input  wire logic [31:0] pwdata,     // apb write data
  output logic      [31:0] prdata,     // apb read data, from flops
  output logic             pready,     // apb ready
  output logic             pslverr,    // apb error on unmapped address
  input  wire logic [7:0]  porta_pin,  // asynchronous port a pins
  input  wire logic [7:0]  portb_pin,  // asynchronous port b pins
  input  wire logic [7:0]  portc_pin,  // asynchronous port c pins
  input  wire logic        sleep_mode, // core is asleep, same clock domain
  output logic             change_irq, // change interrupt to the core
  output logic             wake_req,   // wake request while asleep
  output logic             irq         // masked sticky event interrupt
);

  // raw pins gathered per port, index 0 is port a
  logic [2:0][7:0] pin_raw;
  // first synchroniser stage, read only by the second
  logic [2:0][7:0] sync_meta;
  // second synchroniser stage, the clean sample
  logic [2:0][7:0] sync_pin;
  // previous clean sample for edge comparison
  logic [2:0][7:0] prev_pin;
  // per-pin detected edges
  logic [2:0][7:0] rise_det;
  logic [2:0][7:0] fall_det;
  // per-pin enabled change this cycle
  logic [2:0][7:0] change_hit;
  // software-visible registers
  logic [2:0][7:0] rise_enable;
  logic [2:0][7:0] fall_enable;
  logic [2:0][7:0] change_flags;
  logic            master_en;     // change_master_irq_enable
  logic            aggregate;     // change_aggregate_flag
  logic [2:0]      evt_status;    // sticky per-port event bits
  logic [2:0]      evt_mask;      // mask of the same layout
  // bus decode
  logic            wr_access;     // write completes this edge
  logic            rd_access;     // read completes this edge
  logic            rd_setup;      // setup phase of a read
  logic            addr_mapped;   // address hits a register
  logic [31:0]     next_prdata;   // read data to be latched
  logic [2:0]      hit_rise;
  logic [2:0]      hit_fall;
  logic [2:0]      hit_flags;

  assign pin_raw = {portc_pin, portb_pin, porta_pin};

  // pins come from outside the clock domain
  // two flop synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_meta <= '0;
      sync_pin  <= '0;
    end else begin
      sync_meta <= pin_raw;
      sync_pin  <= sync_meta;
    end
  end

  // keep one older clean sample so each transition is seen once
  // consecutive sample compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_pin <= '0;
    end else begin
      prev_pin <= sync_pin;
    end
  end

  // the edge compare needs two valid samples; until both stages and the
  // previous sample have refilled, a pin already high at reset release
  // would look like a rising edge, so edges stay masked meanwhile
  logic [2:0] sample_fill;  // one bit per stage refilled since reset
  logic       edge_armed;   // clean and previous samples both valid

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_fill <= 3'h0;
    end else begin
      sample_fill <= {sample_fill[1:0], 1'b1};
    end
  end

  assign edge_armed = sample_fill[2];

  // apb: zero wait states, so every access ends in one cycle
  assign pready    = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign rd_setup  = psel & ~penable & ~pwrite;

  // per-port work: decode, enables, edge qualifying, flags
  genvar p;
  generate
    for (p = 0; p < pcd_pkg::PORTS; p++) begin : g_port
      // address hits for this port's three registers
      assign hit_rise[p]  = (paddr == pcd_pkg::ADDR_RISE[p]);
      assign hit_fall[p]  = (paddr == pcd_pkg::ADDR_FALL[p]);
      assign hit_flags[p] = (paddr == pcd_pkg::ADDR_FLAGS[p]);

      // edges from the clean sample against the one before
      assign rise_det[p] = sync_pin[p] & ~prev_pin[p] & {8{edge_armed}};
      assign fall_det[p] = ~sync_pin[p] & prev_pin[p] & {8{edge_armed}};

      assign change_hit[p] = (rise_det[p] & rise_enable[p]) |
                             (fall_det[p] & fall_enable[p]);

      // enable registers, plain read/write
      // enables reset to zero
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rise_enable[p] <= pcd_pkg::ENABLE_RST;
          fall_enable[p] <= pcd_pkg::ENABLE_RST;
        end else if (wr_access) begin
          if (hit_rise[p]) begin
            rise_enable[p] <= pwdata[7:0];
          end
          if (hit_fall[p]) begin
            fall_enable[p] <= pwdata[7:0];
          end
        end
      end

      // flags: written value, then hardware sets on top, so a set
      // landing in the same cycle as a clearing write is never lost
      // flag set on enabled edge
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          change_flags[p] <= pcd_pkg::FLAGS_RST;
        end else if (wr_access && hit_flags[p]) begin
          change_flags[p] <= pwdata[7:0] | change_hit[p];
        end else begin
          change_flags[p] <= change_flags[p] | change_hit[p];
        end
      end

      // enabled rising edge sets the flag on the next edge
      flag_rise_a: assert property (@(posedge pclk) disable iff (!presetn)
        (rise_det[p] & rise_enable[p]) != 8'h00 |=>
          (change_flags[p] & $past(rise_det[p] & rise_enable[p])) ==
          $past(rise_det[p] & rise_enable[p]))
        else $error("enabled rising edge did not set its flag");

      // disabled edges never raise a flag without a write
      flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_access && hit_flags[p]) && change_hit[p] == 8'h00 |=>
          change_flags[p] == $past(change_flags[p]))
        else $error("flag changed without enabled edge or write");

      // a write racing an edge still leaves that flag set
      set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_access && hit_flags[p] |=>
          change_flags[p] == ($past(pwdata[7:0]) | $past(change_hit[p])))
        else $error("flag write lost a concurrent edge");

      // falling edge with fall enable sets flag
      flag_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fall_det[p] & fall_enable[p]) != 8'h00 |=>
          (change_flags[p] & $past(fall_det[p] & fall_enable[p])) != 8'h00)
        else $error("enabled falling edge did not set its flag");
    end
  endgenerate

  // control register: master enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_en <= pcd_pkg::MASTER_RST;
    end else if (wr_access && paddr == pcd_pkg::ADDR_CONTROL) begin
      master_en <= pwdata[pcd_pkg::CTRL_MASTER_BIT];
    end
  end

  // event mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_mask <= pcd_pkg::MASK_RST;
    end else if (wr_access && paddr == pcd_pkg::ADDR_EVT_MASK) begin
      evt_mask <= pwdata[2:0];
    end
  end

  // sticky per-port event bits; a read clears only the bits that it
  // returned, so an event landing on the setup edge is not lost, and
  // an event in the same cycle as the clearing read survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_status <= pcd_pkg::EVT_RST;
    end else begin
      for (int i = 0; i < pcd_pkg::PORTS; i++) begin
        if (change_hit[i] != 8'h00) begin
          evt_status[i] <= 1'b1;
        end else if (rd_access && paddr == pcd_pkg::ADDR_EVT_STATUS && prdata[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  end

  assign aggregate = |change_flags;

  // detection runs regardless; only the interrupt is gated
  // master gates interrupt only
  assign change_irq = master_en & aggregate;

  // flags are flops, so by the time wake is seen they already hold
  // every sleeping edge; the core cannot run before that
  // flags precede wake
  assign wake_req = sleep_mode & change_irq;

  // masked sticky events, also held off by the master enable
  // no irq when master off
  assign irq = master_en & |(evt_status & evt_mask);

  // read mux and map check
  always_comb begin
    next_prdata = 32'h0000_0000;
    addr_mapped = 1'b1;
    case (paddr)
      pcd_pkg::ADDR_PORTA_RISE:  next_prdata[7:0] = rise_enable[0];
      pcd_pkg::ADDR_PORTA_FALL:  next_prdata[7:0] = fall_enable[0];
      pcd_pkg::ADDR_PORTA_FLAGS: next_prdata[7:0] = change_flags[0];
      pcd_pkg::ADDR_PORTB_RISE:  next_prdata[7:0] = rise_enable[1];
      pcd_pkg::ADDR_PORTB_FALL:  next_prdata[7:0] = fall_enable[1];
      pcd_pkg::ADDR_PORTB_FLAGS: next_prdata[7:0] = change_flags[1];
      pcd_pkg::ADDR_PORTC_RISE:  next_prdata[7:0] = rise_enable[2];
      pcd_pkg::ADDR_PORTC_FALL:  next_prdata[7:0] = fall_enable[2];
      pcd_pkg::ADDR_PORTC_FLAGS: next_prdata[7:0] = change_flags[2];
      pcd_pkg::ADDR_CONTROL:     next_prdata[pcd_pkg::CTRL_MASTER_BIT] = master_en;
      pcd_pkg::ADDR_AGGREGATE:   next_prdata[pcd_pkg::AGG_FLAG_BIT] = aggregate;
      pcd_pkg::ADDR_EVT_STATUS:  next_prdata[2:0] = evt_status;
      pcd_pkg::ADDR_EVT_MASK:    next_prdata[2:0] = evt_mask;
      // unmapped: reads zero, flagged as error
      default:                   addr_mapped = 1'b0;
    endcase
  end

  // read data latched in setup so it stands in the access phase;
  // costs one flop bank but keeps prdata glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // error only in the access phase of an unmapped access
  assign pslverr = psel & penable & ~addr_mapped;

  // aggregate tracks the flags exactly
  agg_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    aggregate == (change_flags != 24'h000000))
    else $error("aggregate does not match flags");

  // master off: no change interrupt even with flags set
  master_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !master_en |-> !change_irq && !irq)
    else $error("interrupt raised with master enable off");

  // an enabled edge while asleep raises wake on the next cycle
  wake_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_mode && master_en && change_hit != 24'h000000 &&
    !(wr_access && paddr == pcd_pkg::ADDR_CONTROL) |=> wake_req || !sleep_mode)
    else $error("no wake after enabled edge during sleep");

  // wake never seen before flags hold the edge
  wake_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    wake_req |-> change_flags != 24'h000000)
    else $error("wake before flag recorded");

  // clean sample rises, flag follows one clock later
  sequence pin_rise_s;
    !sync_pin[0][0] ##1 sync_pin[0][0] && rise_enable[0][0] && edge_armed;
  endsequence
  sync_path_a: assert property (@(posedge pclk) disable iff (!presetn)
    pin_rise_s |=> change_flags[0][0])
    else $error("synchronised edge did not reach flag");

  // port b rise enable stores what is written
  enable_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_access && paddr == pcd_pkg::ADDR_PORTB_RISE |=> rise_enable[1] == $past(pwdata[7:0]))
    else $error("enable write not stored");

endmodule // pcd_top

// *** tb/pcd_pins.sv ***
`timescale 1ns/10ps
// far-side pin drivers; levels move only just after a clock edge
module pcd_pins (
  input  wire logic        pclk,      // system clock
  input  wire logic [23:0] want,      // requested levels, port c in the top byte
  output logic      [7:0]  porta_pin, // port a pins
  output logic      [7:0]  portb_pin, // port b pins
  output logic      [7:0]  portc_pin  // port c pins
);
  // pins are driven strongly at all times, so there is no released level to model
  always_ff @(posedge pclk) begin
    {portc_pin, portb_pin, porta_pin} <= want;
  end
endmodule // pcd_pins

// *** tb/tb_pcd_top.sv ***
`timescale 1ns/10ps
// self-checking bench: apb master, pin partner and a read scoreboard
module tb_pcd_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;  // bus and reset
  logic        sleep_mode, change_irq, wake_req, irq;                  // core side
  logic [7:0]  paddr, porta_pin, portb_pin, portc_pin, f;              // address and pins
  logic [31:0] pwdata, prdata;                                         // bus data
  logic [23:0] want, old, re, fe, ex;                                  // pin and enable images
  logic [2:0]  ev;                                                     // expected event status
  logic [32:0] exp_q[$];                                               // read notes
  int          n_mismatch, checks_done, seed;                          // report counters
  pcd_top pcd_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .porta_pin, .portb_pin, .portc_pin, .sleep_mode, .change_irq,
    .wake_req, .irq);
  pcd_pins pcd_pins_i (.pclk, .want, .porta_pin, .portb_pin, .portc_pin);
  // verdict and end of run, the only exit
  task automatic end_sim;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_rd(input string nm, input logic [32:0] e, input logic [32:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_lvl(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // one apb transfer; a read leaves its note before the access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("[FAIL] pready expected 1 seen %b", pready);
      end_sim();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 33'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, {25'h0, e});
  endtask
  // new pin levels, then enough edges for sync and flag update
  task automatic pins(input logic [23:0] v);
    want <= v;
    repeat (5) @(posedge pclk);
  endtask
  // scoreboard: each completed read takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] read note expected 1 seen 0");
      end else begin
        cmp_rd("apb read", exp_q.pop_front(), {pslverr, prdata});
      end
    end
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_mode} = 5'h00;
    {paddr, pwdata, want, n_mismatch, checks_done, ev} = '0;
    seed = $urandom(32'h6a08);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 8'h30; a += 4) rd(8'(a), 8'h00);  // reset values
    apb(1'b0, 8'h34, 32'h0, {1'b1, 32'h0});               // unmapped address errors
    for (int p = 0; p < 3; p++) begin
      re[p*8 +: 8] = 8'($urandom);
      fe[p*8 +: 8] = 8'($urandom);
      wr(pcd_pkg::ADDR_RISE[p], re[p*8 +: 8]);
      wr(pcd_pkg::ADDR_FALL[p], fe[p*8 +: 8]);
      rd(pcd_pkg::ADDR_RISE[p], re[p*8 +: 8]);  // enable read back
      rd(pcd_pkg::ADDR_FALL[p], fe[p*8 +: 8]);  // enable read back
    end
    // random levels, clear, then random transitions on all three ports
    old = 24'($urandom);
    pins(old);
    for (int p = 0; p < 3; p++) ev[p] = |(old[p*8 +: 8] & re[p*8 +: 8]);
    for (int p = 0; p < 3; p++) wr(pcd_pkg::ADDR_FLAGS[p], 8'h00);
    pins(old ^ 24'($urandom));
    ex = (~old & want & re) | (old & ~want & fe);
    for (int p = 0; p < 3; p++) begin
      ev[p] = ev[p] | (|ex[p*8 +: 8]);
      rd(pcd_pkg::ADDR_FLAGS[p], ex[p*8 +: 8]);  // edge flags
    end
    rd(pcd_pkg::ADDR_AGGREGATE, {7'h0, |ex});   // aggregate of flags
    @(negedge pclk);
    cmp_lvl("change_irq", 1'b0, change_irq);    // master off, no interrupt
    rd(pcd_pkg::ADDR_EVT_STATUS, {5'h0, ev});   // sticky event status
    rd(pcd_pkg::ADDR_EVT_STATUS, 8'h00);        // cleared by the read
    // software clear by xor then and, flags stay clear while pins rest
    for (int p = 0; p < 3; p++) begin
      f = ex[p*8 +: 8];
      wr(pcd_pkg::ADDR_FLAGS[p], f & (f ^ 8'hFF));  // masked clear
    end
    repeat (6) @(posedge pclk);
    for (int p = 0; p < 3; p++) rd(pcd_pkg::ADDR_FLAGS[p], 8'h00);  // clear holds
    // wake from sleep on port a pin 0 rising with the master on
    wr(pcd_pkg::ADDR_FALL[0], 8'h00);
    wr(pcd_pkg::ADDR_RISE[0], 8'h01);
    wr(pcd_pkg::ADDR_CONTROL, 8'h01);
    wr(pcd_pkg::ADDR_EVT_MASK, 8'h01);
    rd(pcd_pkg::ADDR_EVT_MASK, 8'h01);
    pins(want & ~24'h1);
    rd(pcd_pkg::ADDR_EVT_STATUS, 8'h00);
    sleep_mode <= 1'b1;
    want <= want | 24'h1;
    for (int n = 0; n < 10 && wake_req !== 1'b1; n++) @(negedge pclk);
    cmp_lvl("wake_req", 1'b1, wake_req);  // wake on change
    if (wake_req !== 1'b1) end_sim();
    cmp_lvl("irq", 1'b1, irq);
    rd(pcd_pkg::ADDR_FLAGS[0], 8'h01);    // flag ready at wake
    wr(pcd_pkg::ADDR_CONTROL, 8'h00);
    @(negedge pclk);
    cmp_lvl("change_irq", 1'b0, change_irq);  // master off
    cmp_lvl("wake_req", 1'b0, wake_req);      // no wake without master
    cmp_lvl("irq", 1'b0, irq);
    rd(pcd_pkg::ADDR_AGGREGATE, 8'h01);       // aggregate still set
    rd(pcd_pkg::ADDR_EVT_STATUS, 8'h01);
    // falling edge landing on the access edge of a clearing write
    wr(pcd_pkg::ADDR_FLAGS[0], 8'h00);
    wr(pcd_pkg::ADDR_FALL[0], 8'h01);
    want <= want & ~24'h1;
    @(posedge pclk);
    wr(pcd_pkg::ADDR_FLAGS[0], 8'h00);
    rd(pcd_pkg::ADDR_FLAGS[0], 8'h01);  // edge wins over clear
    // second reset in mid-run
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(pcd_pkg::ADDR_RISE[0], 8'h00);   // enable reset
    rd(pcd_pkg::ADDR_FLAGS[0], 8'h00);  // flag reset
    repeat (2) @(posedge pclk);
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("[FAIL] open notes expected 0 seen %0d", exp_q.size());
    end
    end_sim();
  end
endmodule // tb_pcd_top
